// ===== core/tlom_defs.svh
// Constants of the torque limit and output map block
// Assumes a 32-bit classic Wishbone slave with byte addresses
`ifndef TLOM_DEFS_SVH
`define TLOM_DEFS_SVH
// ====================================================================
// Register byte offsets
`define TLOM_A_OUT_SEL   8'h00
`define TLOM_A_OUT_OR0   8'h04
`define TLOM_A_FWD_INT   8'h10
`define TLOM_A_REV_INT   8'h14
`define TLOM_A_FWD_EXT   8'h18
`define TLOM_A_REV_EXT   8'h1C
`define TLOM_A_MAX_LIM   8'h20
`define TLOM_A_IN_ALLOC  8'h24
`define TLOM_A_REMOTE    8'h28
`define TLOM_A_STATUS    8'h2C
`define TLOM_A_TQ_OUT    8'h30
`define TLOM_OR_STRIDE   8'h04
// ====================================================================
// Reset values and ranges, percent of rated torque
`define TLOM_INT_DEF     9'h12C
`define TLOM_EXT_DEF     9'h064
`define TLOM_LIM_TOP     9'h15E
`define TLOM_MAX_DEF     9'h15E
`define TLOM_OUT_SEL_DEF 12'h000
// ====================================================================
// Output source codes and input allocation codes
`define TLOM_SRC_CLT     4'h3
`define TLOM_SRC_REM0    4'h9
`define TLOM_SRC_REM1    4'hA
`define TLOM_SRC_REM2    4'hB
`define TLOM_IN_FWD      3'h3
`define TLOM_IN_REV      3'h4
`define TLOM_IN_DEF      15'h0000
`endif

// ===== core/tlom_pkg.sv
// Types shared by the torque limit and output map block
// Assumes the constants header is compiled alongside
package tlom_pkg;
    // ================================================================
    // Internal status signals that may be routed to output slots
    typedef struct packed {
        logic torque_detected_flag;
        logic motor_excited;
        logic overtravel_flag;
        logic encoder_index_pulse;
        logic brake_control;
        logic servo_ready;
        logic rotation_detected;
        logic position_or_speed_match;
    } tlom_stat_s;

    // State of the output map
    typedef struct packed {
        logic [2:0] slot;
    } tlom_map_s;

    // State of the top module
    typedef struct packed {
        logic               ack;
        logic [31:0]        rdat;
        logic [11:0]        out_sel;
        logic [2:0][11:0]   or_mask;
        logic [8:0]         fwd_int;
        logic [8:0]         rev_int;
        logic [8:0]         fwd_ext;
        logic [8:0]         rev_ext;
        logic [8:0]         max_lim;
        logic [14:0]        in_alloc;
        logic [2:0]         remote;
        logic [4:0]         s1;
        logic [4:0]         s2;
        logic [4:0]         s3;
        logic [4:0]         pins;
        logic               fwd_req;
        logic               rev_req;
        logic signed [11:0] tq_out;
        logic [8:0]         act_lim;
        logic               clt;
    } tlom_state_s;
endpackage : tlom_pkg

// ===== core/tlom_out_map.sv
// Output slot router: each slot ORs its selected status sources
// Assumes sources come from logic on the same clock
`timescale 1ns/10ps
`include "tlom_defs.svh"
module tlom_out_map
    import tlom_pkg::*;
#(
    parameter int NUM_SLOTS = 3,
    parameter int NUM_SRC   = 12
) (
    input  wire logic                      clk_i,   // Clock
    input  wire logic                      rst_i,   // Sync reset
    input  wire logic [NUM_SRC-1:0]        src_i,   // Source vector by code
    input  wire logic [4*NUM_SLOTS-1:0]    code_i,  // One code per slot
    input  wire logic [NUM_SLOTS*NUM_SRC-1:0] mask_i, // Extra sources per slot
    output logic [NUM_SLOTS-1:0]           slot_o   // Slot outputs
);
    // ================================================================
    // Parameter check at elaboration
    if (NUM_SLOTS != 3 || NUM_SRC != 12) begin : g_bad_size
        $error("tlom_out_map: only 3 slots of 12 sources supported");
    end

    tlom_map_s         st_ff, nxt_st;
    logic [NUM_SLOTS-1:0] hit;

    // ================================================================
    // Per slot selection: coded source ORed with extra sources
    for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
        logic [NUM_SRC-1:0] sel;
        always_comb begin
            sel = mask_i[g*NUM_SRC +: NUM_SRC];
            for (int k = 0; k < NUM_SRC; k++) begin
                if (code_i[4*g +: 4] == 4'(k))
                    sel[k] = 1'b1;
            end
        end
        assign hit[g] = |(sel & src_i);
    end

    // Next state
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.slot = hit;
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) st_ff <= '0;
        else       st_ff <= nxt_st;
    end

    assign slot_o = st_ff.slot;

    // ================================================================
    // Checks
    a_slot_or_sources: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (|(mask_i[NUM_SRC-1:0] & src_i)) |=> slot_o[0])
        else $error("slot 0 missed an ORed source");
    a_remote_route: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (code_i[3:0] == `TLOM_SRC_REM0 && mask_i[NUM_SRC-1:0] == '0)
        |=> slot_o[0] == $past(src_i[`TLOM_SRC_REM0]))
        else $error("remote output 0 not routed to slot 0");
endmodule : tlom_out_map

// ===== core/tlom_top.sv
// Torque limit selection and output slot routing, Wishbone slave
// Assumes torque command and status inputs share clk_i; pins are async
// Overview of operation
// - Three output slots, each with source select
// - Several sources on one slot are ORed
// - Codes 0..8 pick the listed status signals, with code 3 picking the limiting flag
// - Codes 9, A, B pick remote outputs
// - Internal limits 0..350 percent, default 300
// - Forward request on: min of internal, external
// - Forward request off: forward external setting alone
// - Reverse request on: min of internal, external
// - Reverse request off: reverse external setting alone
// - Never exceed motor maximum torque limit
// - Limiting flag high while torque is limited
// - Input code 3 forward, 4 reverse
`timescale 1ns/10ps
`include "tlom_defs.svh"
module tlom_top
    import tlom_pkg::*;
#(
    parameter int NUM_PINS = 5
) (
    input  wire logic               clk_i,        // 250 MHz clock
    input  wire logic               rst_i,        // Sync reset, high
    input  wire logic               wb_cyc_i,     // Bus cycle
    input  wire logic               wb_stb_i,     // Strobe
    input  wire logic               wb_we_i,      // Write enable
    input  wire logic [7:0]         wb_adr_i,     // Byte address
    input  wire logic [3:0]         wb_sel_i,     // Byte lanes
    input  wire logic [31:0]        wb_dat_i,     // Write data
    output logic [31:0]             wb_dat_o,     // Read data
    output logic                    wb_ack_o,     // Acknowledge
    input  wire logic [NUM_PINS-1:0] in_pins_i,   // Allocatable input pins
    input  wire tlom_stat_s         status_i,     // Internal status signals
    input  wire logic signed [11:0] torque_cmd_i, // Commanded torque, percent
    output logic signed [11:0]      torque_out_o, // Limited torque
    output logic                    torque_limiting_flag_o, // Limiting now
    output logic [2:0]              slot_o        // Output slot pins
);
    // ================================================================
    // Parameter check at elaboration
    if (NUM_PINS != 5) begin : g_bad_pins
        $error("tlom_top: five input pins required");
    end

    tlom_state_s  st_ff, nxt_st;
    logic         req;
    logic [31:0]  wmrg;
    logic [31:0]  rd;
    logic [11:0]  mag;
    logic [8:0]   lim;
    logic [8:0]   lf;
    logic [8:0]   lr;
    logic         fwd_dir;
    logic [11:0]  src;

    // Smaller of two limits
    function automatic logic [8:0] min9(input logic [8:0] a, input logic [8:0] b);
        min9 = (a < b) ? a : b;
    endfunction : min9

    // Range clamp for limit writes
    function automatic logic [8:0] clip(input logic [31:0] v);
        clip = (v[31:9] != '0 || v[8:0] > `TLOM_LIM_TOP) ? `TLOM_LIM_TOP : v[8:0];
    endfunction : clip

    // Byte lane merge of write data into an old word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) r[8*b +: 8] = d[8*b +: 8];
        end
        merge = r;
    endfunction : merge

    // ================================================================
    // Request decode and read mux
    assign req = wb_cyc_i && wb_stb_i && !st_ff.ack;

    always_comb begin
        unique case (wb_adr_i)
            `TLOM_A_OUT_SEL:   rd = {20'h00000, st_ff.out_sel};
            `TLOM_A_OUT_OR0:   rd = {20'h00000, st_ff.or_mask[0]};
            `TLOM_A_OUT_OR0 + `TLOM_OR_STRIDE:
                               rd = {20'h00000, st_ff.or_mask[1]};
            `TLOM_A_OUT_OR0 + `TLOM_OR_STRIDE + `TLOM_OR_STRIDE:
                               rd = {20'h00000, st_ff.or_mask[2]};
            `TLOM_A_FWD_INT:   rd = {23'h000000, st_ff.fwd_int};
            `TLOM_A_REV_INT:   rd = {23'h000000, st_ff.rev_int};
            `TLOM_A_FWD_EXT:   rd = {23'h000000, st_ff.fwd_ext};
            `TLOM_A_REV_EXT:   rd = {23'h000000, st_ff.rev_ext};
            `TLOM_A_MAX_LIM:   rd = {23'h000000, st_ff.max_lim};
            `TLOM_A_IN_ALLOC:  rd = {17'h00000, st_ff.in_alloc};
            `TLOM_A_REMOTE:    rd = {29'h00000000, st_ff.remote};
            `TLOM_A_STATUS:    rd = {14'h0000, st_ff.act_lim, st_ff.pins,
                                     1'b0, st_ff.clt, st_ff.rev_req, st_ff.fwd_req};
            `TLOM_A_TQ_OUT:    rd = {{20{st_ff.tq_out[11]}}, st_ff.tq_out};
            default:           rd = 32'h00000000;
        endcase
        wmrg = merge(rd, wb_dat_i, wb_sel_i);
    end

    // ================================================================
    // Active limit for the commanded direction
    always_comb begin
        // Forward: request on takes the smaller, off takes external alone
        lf = st_ff.fwd_req ? min9(st_ff.fwd_int, st_ff.fwd_ext)
                           : st_ff.fwd_ext;
        lr = st_ff.rev_req ? min9(st_ff.rev_int, st_ff.rev_ext)
                           : st_ff.rev_ext;
        fwd_dir = !torque_cmd_i[11];
        lim = min9(fwd_dir ? lf : lr, st_ff.max_lim);
        mag = fwd_dir ? 12'(torque_cmd_i) : 12'(-torque_cmd_i);
    end

    // ================================================================
    // Next state: bus, pin synchroniser, allocation, limiting
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.ack  = req;
        nxt_st.rdat = req ? rd : st_ff.rdat;
        if (req && wb_we_i) begin
            unique case (wb_adr_i)
                `TLOM_A_OUT_SEL:  nxt_st.out_sel = wmrg[11:0];
                `TLOM_A_OUT_OR0:  nxt_st.or_mask[0] = wmrg[11:0];
                `TLOM_A_OUT_OR0 + `TLOM_OR_STRIDE:
                                  nxt_st.or_mask[1] = wmrg[11:0];
                `TLOM_A_OUT_OR0 + `TLOM_OR_STRIDE + `TLOM_OR_STRIDE:
                                  nxt_st.or_mask[2] = wmrg[11:0];
                `TLOM_A_FWD_INT:  nxt_st.fwd_int = clip(wmrg);
                `TLOM_A_REV_INT:  nxt_st.rev_int = clip(wmrg);
                `TLOM_A_FWD_EXT:  nxt_st.fwd_ext = clip(wmrg);
                `TLOM_A_REV_EXT:  nxt_st.rev_ext = clip(wmrg);
                `TLOM_A_MAX_LIM:  nxt_st.max_lim = clip(wmrg);
                `TLOM_A_IN_ALLOC: nxt_st.in_alloc = wmrg[14:0];
                `TLOM_A_REMOTE:   nxt_st.remote = wmrg[2:0];
                default:          nxt_st.ack = req;
            endcase
        end
        // Three flops; a pin change counts once stages two and three agree
        nxt_st.s1 = in_pins_i;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        for (int i = 0; i < NUM_PINS; i++) begin
            if (st_ff.s2[i] == st_ff.s3[i]) nxt_st.pins[i] = st_ff.s3[i];
        end
        // Higher pin wins where a request is allocated twice
        nxt_st.fwd_req = 1'b0;
        nxt_st.rev_req = 1'b0;
        for (int i = 0; i < NUM_PINS; i++) begin
            if (st_ff.in_alloc[3*i +: 3] == `TLOM_IN_FWD)
                nxt_st.fwd_req = st_ff.pins[i];
            if (st_ff.in_alloc[3*i +: 3] == `TLOM_IN_REV)
                nxt_st.rev_req = st_ff.pins[i];
        end
        // Saturate the command and flag the limiting
        nxt_st.act_lim = lim;
        if (mag > {3'b000, lim}) begin
            nxt_st.tq_out = fwd_dir ? $signed({3'b000, lim})
                                    : -$signed({3'b000, lim});
            nxt_st.clt    = 1'b1;
        end else begin
            nxt_st.tq_out = torque_cmd_i;
            nxt_st.clt    = 1'b0;
        end
    end

    // ================================================================
    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff          <= '0;
            st_ff.out_sel  <= `TLOM_OUT_SEL_DEF;
            st_ff.fwd_int  <= `TLOM_INT_DEF;
            st_ff.rev_int  <= `TLOM_INT_DEF;
            st_ff.fwd_ext  <= `TLOM_EXT_DEF;
            st_ff.rev_ext  <= `TLOM_EXT_DEF;
            st_ff.max_lim  <= `TLOM_MAX_DEF;
            st_ff.in_alloc <= `TLOM_IN_DEF;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from flops
    assign wb_ack_o               = st_ff.ack;
    assign wb_dat_o               = st_ff.rdat;
    assign torque_out_o           = st_ff.tq_out;
    assign torque_limiting_flag_o = st_ff.clt;

    // ================================================================
    // Source vector by code, then the slot router
    assign src = {st_ff.remote,
                  status_i.torque_detected_flag,
                  status_i.motor_excited,
                  status_i.overtravel_flag,
                  status_i.encoder_index_pulse,
                  status_i.brake_control,
                  st_ff.clt,
                  status_i.servo_ready,
                  status_i.rotation_detected,
                  status_i.position_or_speed_match};

    tlom_out_map #(
        .NUM_SLOTS (3),
        .NUM_SRC   (12)
    ) u_map (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .src_i  (src),
        .code_i (st_ff.out_sel),
        .mask_i (st_ff.or_mask),
        .slot_o (slot_o)
    );

    // ================================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Bus handshake: ack one cycle after the take, for one cycle only
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    // Read data holds between requests
    a_rdat_hold: assert property (
        !(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> $stable(wb_dat_o))
        else $error("read data changed without a request");

    // Limit settings stay inside the writable range
    a_int_range_ok: assert property (
        st_ff.fwd_int <= `TLOM_LIM_TOP && st_ff.rev_int <= `TLOM_LIM_TOP)
        else $error("internal limit beyond range");
    a_ext_range_ok: assert property (
        st_ff.fwd_ext <= `TLOM_LIM_TOP && st_ff.rev_ext <= `TLOM_LIM_TOP
        && st_ff.max_lim <= `TLOM_LIM_TOP)
        else $error("external or maximum limit beyond range");
    a_write_clip: assert property (
        req && wb_we_i && wb_adr_i == `TLOM_A_FWD_INT && &wb_sel_i
        && wb_dat_i > 32'(`TLOM_LIM_TOP) |=> st_ff.fwd_int == `TLOM_LIM_TOP)
        else $error("forward internal write not clamped to range");

    // Active limit per direction and request level
    a_fwd_on_min: assert property (
        st_ff.fwd_req && !torque_cmd_i[11]
        |=> st_ff.act_lim <= $past(st_ff.fwd_int)
            && st_ff.act_lim <= $past(st_ff.fwd_ext))
        else $error("forward limit above internal or external");
    a_fwd_off_ext: assert property (
        !st_ff.fwd_req && !torque_cmd_i[11] && st_ff.fwd_ext <= st_ff.max_lim
        |=> st_ff.act_lim == $past(st_ff.fwd_ext))
        else $error("forward limit not external setting");
    a_rev_on_min: assert property (
        st_ff.rev_req && torque_cmd_i[11]
        |=> st_ff.act_lim <= $past(st_ff.rev_int)
            && st_ff.act_lim <= $past(st_ff.rev_ext))
        else $error("reverse limit above internal or external");
    a_rev_off_ext: assert property (
        !st_ff.rev_req && torque_cmd_i[11] && st_ff.rev_ext <= st_ff.max_lim
        |=> st_ff.act_lim == $past(st_ff.rev_ext))
        else $error("reverse limit not external setting");
    a_max_bound: assert property (st_ff.act_lim <= $past(st_ff.max_lim))
        else $error("active limit above motor maximum");

    // Flag and saturation follow the excess of the command
    a_flag_on_excess: assert property (
        mag > {3'b000, lim} |=> torque_limiting_flag_o)
        else $error("limiting flag missing on excess command");
    a_flag_off_fit: assert property (
        mag <= {3'b000, lim} |=> !torque_limiting_flag_o)
        else $error("limiting flag set on fitting command");
    a_flag_sat: assert property (
        torque_limiting_flag_o
        |-> torque_out_o == $signed({3'b000, st_ff.act_lim})
            || torque_out_o == -$signed({3'b000, st_ff.act_lim}))
        else $error("flag set without saturated output");
    a_sat_fwd: assert property (
        !torque_cmd_i[11] && mag > {3'b000, lim}
        |=> torque_out_o == $signed({3'b000, $past(lim)}))
        else $error("forward command not saturated to limit");
    a_sat_rev: assert property (
        torque_cmd_i[11] && mag > {3'b000, lim}
        |=> torque_out_o == -$signed({3'b000, $past(lim)}))
        else $error("reverse command not saturated to limit");
    a_cmd_pass: assert property (
        !torque_limiting_flag_o |-> torque_out_o == $past(torque_cmd_i))
        else $error("unlimited command not passed through");

    // Limiting flag reaches a slot through its source code
    a_flag_route: assert property (
        st_ff.out_sel[3:0] == `TLOM_SRC_CLT && st_ff.or_mask[0] == '0
        |=> slot_o[0] == $past(st_ff.clt))
        else $error("limiting flag not routed to slot 0");

    // Requests come only from allocated pins that are on
    a_pins_idle: assert property (
        st_ff.pins == '0 |=> !st_ff.fwd_req && !st_ff.rev_req)
        else $error("limit request without any pin on");
endmodule : tlom_top

// ===== bench/tlom_host_model.sv
// Host controller model: drives the allocatable input pins
// Assumes pin FWD_PIN carries the forward request, REV_PIN the reverse one
`timescale 1ns/10ps
module tlom_host_model #(
    parameter int NUM_PINS = 5,
    parameter int FWD_PIN  = 0,
    parameter int REV_PIN  = 1
) (
    input  wire logic                clk_i,      // Host clock
    input  wire logic                fwd_want_i, // Host wants forward limit
    input  wire logic                rev_want_i, // Host wants reverse limit
    output logic [NUM_PINS-1:0]      pins_o      // Discrete input pins
);
    // ================================================================
    // Unused pins toggle so no stale level is ever mistaken for a request
    logic [NUM_PINS-1:0] noise_ff = '0;
    always @(posedge clk_i) begin
        noise_ff <= {noise_ff[NUM_PINS-2:0], ~noise_ff[NUM_PINS-1]};
    end
    // Requests land on their allocated pins, active high means ON
    always_comb begin
        pins_o          = noise_ff;
        pins_o[FWD_PIN] = fwd_want_i;
        pins_o[REV_PIN] = rev_want_i;
    end
endmodule : tlom_host_model

// ===== bench/torque_limit_and_output_map_tb_top.sv
// Testbench of the torque limit and output map block
// Assumes the design package, header and host model are compiled first
`timescale 1ns/10ps
`include "tlom_defs.svh"
module torque_limit_and_output_map_tb_top;
    import tlom_pkg::*;
    // ================================================================
    // Signals and reference mirrors
    logic               clk_i    = 1'b0;
    logic               rst_i    = 1'b1;
    logic               wb_cyc   = 1'b0;
    logic               wb_stb   = 1'b0;
    logic               wb_we    = 1'b0;
    logic [3:0]         wb_sel   = 4'h0;
    logic [7:0]         wb_adr   = 8'h00;
    logic [31:0]        wb_wdat  = 32'h00000000;
    logic [31:0]        wb_rdat;
    logic               wb_ack;
    logic [4:0]         pins;
    logic               fwd_want = 1'b0;
    logic               rev_want = 1'b0;
    logic               chk_stb  = 1'b0;
    logic [7:0]         st       = 8'h00;
    logic signed [11:0] cmd      = 12'sh000;
    logic signed [11:0] tq_out;
    logic               flag;
    logic [2:0]         slot;
    logic [11:0]        sel      = 12'h000;
    logic [35:0]        msk      = 36'h000000000;
    logic [2:0]         rem      = 3'h0;
    logic [31:0]        rd_q[$];
    logic [15:0]        out_q[$];
    int                 fi, ri, fe, re, mx;
    int                 error_cnt  = 0;
    int                 n_compared = 0;
    logic [7:0]  adr_t[11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
                               8'h18, 8'h1C, 8'h20, 8'h24, 8'hFC};
    logic [31:0] rv_t[11]  = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h12C, 32'h12C,
                               32'h64, 32'h64, 32'h15E, 32'h0, 32'h0};

    // Free-running 250 MHz clock
    always #2 clk_i = ~clk_i;

    tlom_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .in_pins_i(pins), .status_i(st),
        .torque_cmd_i(cmd), .torque_out_o(tq_out), .torque_limiting_flag_o(flag),
        .slot_o(slot));
    tlom_host_model host_u (.clk_i(clk_i), .fwd_want_i(fwd_want),
        .rev_want_i(rev_want), .pins_o(pins));

    // ================================================================
    // Compare, verdict and bus tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    // One classic cycle; entered just after a rising edge
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= we;
        wb_sel  <= 4'hF;
        wb_adr  <= adr;
        wb_wdat <= d;
        @(posedge clk_i);
        while (wb_ack !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (n == 20) begin
            error_cnt++;
            close_out();
        end else begin
            @(posedge clk_i);
        end
    endtask : wb_cycle

    task automatic wb_rd(input logic [7:0] adr, input logic [31:0] exp);
        rd_q.push_back(exp);
        wb_cycle(1'b0, adr, 32'h0);
    endtask : wb_rd

    // Reference of the torque path and the slot router
    function automatic logic [15:0] exp_out();
        int c, lim, o;
        logic f;
        logic [11:0] src;
        logic [2:0] s;
        c   = int'(cmd);
        lim = (c >= 0) ? (fwd_want ? ((fi < fe) ? fi : fe) : fe)
                       : (rev_want ? ((ri < re) ? ri : re) : re);
        if (lim > mx) lim = mx;
        f   = (c > lim) || (-c > lim);
        o   = (c > lim) ? lim : ((-c > lim) ? -lim : c);
        src = {rem, st[7:3], f, st[2:0]};
        for (int k = 0; k < 3; k++) begin
            s[k] = ((sel[4*k+:4] < 4'hC) ? src[sel[4*k+:4]] : 1'b0)
                 | (|(src & msk[12*k+:12]));
        end
        return {f, s, o[11:0]};
    endfunction : exp_out

    // Let pin synchronisers and pipelines settle, then note and strobe a check
    task automatic check_out();
        repeat (12) @(posedge clk_i);
        out_q.push_back(exp_out());
        chk_stb <= 1'b1;
        @(posedge clk_i);
        chk_stb <= 1'b0;
    endtask : check_out

    // ================================================================
    // Monitor: takes the oldest note whenever a result appears
    always @(posedge clk_i) begin
        if (wb_ack === 1'b1 && wb_we === 1'b0 && rd_q.size() > 0) begin
            chk(wb_rdat, rd_q.pop_front());
        end
        if (chk_stb === 1'b1 && out_q.size() > 0) begin
            chk({16'h0, flag, slot, tq_out}, {16'h0, out_q.pop_front()});
        end
    end

    // Watchdog cuts a hung run short
    initial begin
        repeat (100000) @(posedge clk_i);
        error_cnt++;
        close_out();
    end

    // ================================================================
    // Main sequence
    initial begin
        void'($urandom(46646));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // Reset values, unmapped address reads zero
        for (int i = 0; i < 11; i++) wb_rd(adr_t[i], rv_t[i]);
        wb_cycle(1'b1, `TLOM_A_FWD_INT, 32'h1FF);
        wb_rd(`TLOM_A_FWD_INT, 32'h15E);
        $display("test reset_values done");
        // Pin 0 forward request, pin 1 reverse request
        wb_cycle(1'b1, `TLOM_A_IN_ALLOC, 32'h23);
        for (int it = 0; it < 48; it++) begin
            fi = $urandom_range(350, 0);
            ri = $urandom_range(350, 0);
            fe = $urandom_range(350, 0);
            re = $urandom_range(350, 0);
            mx = (it % 3 == 0) ? $urandom_range(350, 0) : 350;
            wb_cycle(1'b1, `TLOM_A_FWD_INT, 32'(fi));
            wb_cycle(1'b1, `TLOM_A_REV_INT, 32'(ri));
            wb_cycle(1'b1, `TLOM_A_FWD_EXT, 32'(fe));
            wb_cycle(1'b1, `TLOM_A_REV_EXT, 32'(re));
            wb_cycle(1'b1, `TLOM_A_MAX_LIM, 32'(mx));
            fwd_want <= 1'($urandom_range(1, 0));
            rev_want <= 1'($urandom_range(1, 0));
            cmd      <= 12'($urandom_range(840, 0) - 420);
            check_out();
        end
        $display("test torque_limits done");
        // Every source code in turn, with random OR masks and sources
        for (int c = 0; c < 16; c++) begin
            sel = 12'($urandom());
            sel[4*(c%3)+:4] = 4'(c);
            msk = 36'({$urandom() & $urandom() & $urandom(), $urandom()}) & 36'hFFF00F00F;
            if (c % 3 == 0) msk[11:0] = 12'h000; // Bare code on slot 0
            rem = 3'($urandom());
            wb_cycle(1'b1, `TLOM_A_OUT_SEL, {20'h0, sel});
            for (int k = 0; k < 3; k++) begin
                wb_cycle(1'b1, 8'(`TLOM_A_OUT_OR0 + k * `TLOM_OR_STRIDE),
                         {20'h0, msk[12*k+:12]});
            end
            wb_cycle(1'b1, `TLOM_A_REMOTE, {29'h0, rem});
            st  <= 8'($urandom());
            cmd <= 12'($urandom_range(840, 0) - 420);
            check_out();
        end
        $display("test output_slots done");
        close_out();
    end
endmodule : torque_limit_and_output_map_tb_top
